//--- hw/interrupt_vector_priority_map.sv
/*
 * Interrupt vector and priority map: 24 requests, two-bit level each,
 * fixed number order on ties, vector address to the CPU core.
 * Assumes request lines are synchronous to sys_clk and level writes
 * come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_priority_map (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Generic request lines, one per request number
    input  wire logic [23:0]            irq_req,
    // Timer and pulse generator halves
    input  wire logic                   timer0_lo_irq,
    input  wire logic                   timer0_hi_irq,
    input  wire logic                   timer1_lo_irq,
    input  wire logic                   timer1_hi_irq,
    input  wire logic                   programmable_pulse_generator0_lo_irq,
    input  wire logic                   programmable_pulse_generator0_hi_irq,
    input  wire logic                   programmable_pulse_generator1_lo_irq,
    input  wire logic                   programmable_pulse_generator1_hi_irq,
    // Level field write port
    input  wire irq_map_pkg::level_wr_t level_wr,
    // CPU current interrupt level
    input  wire logic [1:0]             cpu_level,
    // Request to the CPU core and level field read-out
    output var irq_map_pkg::irq_sel_t   cpu_irq_q,
    output logic [15:0]                 vec_lo_addr_q,
    output logic [47:0]                 levels_q
);
    import irq_map_pkg::*;

    // ****************************************************************
    // Request mapping
    // ****************************************************************
    logic [23:0] req_all;

    // Merge peripheral halves onto their request numbers
    always_comb begin
        req_all = irq_req;
        req_all[REQ_CT0_LO] = irq_req[REQ_CT0_LO] | timer0_lo_irq;
        req_all[REQ_CT0_HI] = irq_req[REQ_CT0_HI] | timer0_hi_irq;
        req_all[REQ_CT1_HI] = irq_req[REQ_CT1_HI] | timer1_hi_irq;
        req_all[REQ_CT1_LO] = irq_req[REQ_CT1_LO] | timer1_lo_irq;
        req_all[REQ_PG1_LO] = irq_req[REQ_PG1_LO]
                            | programmable_pulse_generator1_lo_irq;
        req_all[REQ_PG1_HI] = irq_req[REQ_PG1_HI]
                            | programmable_pulse_generator1_hi_irq;
        req_all[REQ_PG0_HI] = irq_req[REQ_PG0_HI]
                            | programmable_pulse_generator0_hi_irq;
        req_all[REQ_PG0_LO] = irq_req[REQ_PG0_LO]
                            | programmable_pulse_generator0_lo_irq;
    end

    // ****************************************************************
    // Level field store
    // ****************************************************************
    // Fields indexed by request number
    irq_level_store u_store (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .wr       (level_wr),
        .levels_q (levels_q)
    );

    // ****************************************************************
    // Selection
    // ****************************************************************
    irq_sel_t   sel_d;
    logic [1:0] lvl_i;
    logic [1:0] best_lvl;

    // Most urgent level wins, ties to lowest number (scan high to low)
    always_comb begin
        sel_d    = '0;
        best_lvl = 2'h3;
        lvl_i    = 2'h3;
        for (int i = REQ_COUNT - 1; i >= 0; i--) begin
            lvl_i = levels_q[2*i +: 2];
            // level must beat the CPU level; lower value is more urgent
            if (req_all[i] && (lvl_i < cpu_level) && (lvl_i <= best_lvl)) begin
                best_lvl       = lvl_i;
                sel_d.valid    = 1'b1;
                sel_d.req      = 5'(i);
                sel_d.level    = lvl_i;
            end
        end
        sel_d.vec_addr = sel_d.valid ? VEC_BASE - {10'h000, sel_d.req, 1'b0}
                                     : 16'h0000;
    end

    // Output registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cpu_irq_q     <= '0;
            vec_lo_addr_q <= 16'h0000;
        end else begin
            cpu_irq_q     <= sel_d;
            vec_lo_addr_q <= sel_d.valid ? sel_d.vec_addr + 16'h0001 : 16'h0000;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Upper vector byte address follows the table
    vec_table_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_irq_q.valid |-> cpu_irq_q.vec_addr ==
            16'hfffa - {10'h000, cpu_irq_q.req, 1'b0})
        else $error("vector address not in table");

    // Lower vector byte sits one address above
    vec_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_irq_q.valid |-> vec_lo_addr_q == cpu_irq_q.vec_addr + 16'h0001)
        else $error("lower vector byte not next address");

    // Forwarded level beats the CPU level
    cpu_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_irq_q.valid |-> cpu_irq_q.level < $past(cpu_level))
        else $error("forwarded level not above cpu level");

    // Request 0 at level 0 wins whenever the CPU level is above 0
    tie_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($past(req_all[0]) && $past(levels_q[1:0]) == 2'h0 &&
         $past(cpu_level) != 2'h0) |-> cpu_irq_q.req == 5'h00)
        else $error("request 0 not first");

    // Timer channel 0 lower half alone reaches its vector
    timer0_lo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer0_lo_irq && irq_req == 24'h000000 && levels_q[11:10] == 2'h0 &&
         cpu_level == 2'h3 && !(|{timer0_hi_irq, timer1_lo_irq, timer1_hi_irq,
         programmable_pulse_generator0_lo_irq, programmable_pulse_generator0_hi_irq,
         programmable_pulse_generator1_lo_irq, programmable_pulse_generator1_hi_irq})
         && $stable(levels_q)) |=> cpu_irq_q.vec_addr == 16'hfff0)
        else $error("timer 0 lower half vector wrong");

    // Timer channel 1 upper half vector pair
    timer1_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_irq_q.valid && cpu_irq_q.req == 5'h0e) |->
            cpu_irq_q.vec_addr == 16'hffde && vec_lo_addr_q == 16'hffdf)
        else $error("timer 1 upper half vector wrong");

    // Timer channel 1 lower half vector pair
    timer1_lo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_irq_q.valid && cpu_irq_q.req == 5'h16) |->
            cpu_irq_q.vec_addr == 16'hffce && vec_lo_addr_q == 16'hffcf)
        else $error("timer 1 lower half vector wrong");

    // Pulse generator channel 1 lower half vector
    pulse_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_irq_q.valid && cpu_irq_q.req == 5'h09) |->
            cpu_irq_q.vec_addr == 16'hffe8)
        else $error("pulse generator 1 lower vector wrong");

    // Pulse generator channel 0 upper half vector
    pulse0_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_irq_q.valid && cpu_irq_q.req == 5'h0c) |->
            cpu_irq_q.vec_addr == 16'hffe2)
        else $error("pulse generator 0 upper vector wrong");

    // Writes to existing fields land one edge later
    level_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (level_wr.we && level_wr.req < 5'(REQ_COUNT)) |=>
            levels_q[{$past(level_wr.req), 1'b0} +: 2] == $past(level_wr.level))
        else $error("level field not written");

    // Writes past the last request leave every field alone
    write_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (level_wr.we && level_wr.req >= 5'(REQ_COUNT)) |=> $stable(levels_q))
        else $error("out of range level write changed a field");

    // Reset puts every field at level 3 and drops the request
    reset_clear_a: assert property (@(posedge sys_clk)
        !rst_n |=> !cpu_irq_q.valid && levels_q == LEVELS_RESET)
        else $error("reset did not clear levels and request");

    // Timer channel 0 upper half vector pair
    timer0_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_irq_q.valid && cpu_irq_q.req == 5'h06) |->
            cpu_irq_q.vec_addr == 16'hffee && vec_lo_addr_q == 16'hffef)
        else $error("timer 0 upper half vector wrong");

    // Pulse generator channel 1 upper half vector pair
    pulse1_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_irq_q.valid && cpu_irq_q.req == 5'h0a) |->
            cpu_irq_q.vec_addr == 16'hffe6 && vec_lo_addr_q == 16'hffe7)
        else $error("pulse generator 1 upper vector wrong");

    // Pulse generator channel 0 lower half vector pair
    pulse0_lo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_irq_q.valid && cpu_irq_q.req == 5'h0d) |->
            cpu_irq_q.vec_addr == 16'hffe0 && vec_lo_addr_q == 16'hffe1)
        else $error("pulse generator 0 lower vector wrong");

    // Level 3 is never forwarded
    masked_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_irq_q.valid |-> cpu_irq_q.level != 2'h3)
        else $error("level 3 request forwarded");

    // No pending request, nothing forwarded at the next edge
    idle_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_all == 24'h000000 |=> !cpu_irq_q.valid)
        else $error("request forwarded with none pending");

    // Vector outputs read zero while nothing is forwarded
    vec_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cpu_irq_q.valid |->
            cpu_irq_q.vec_addr == 16'h0000 && vec_lo_addr_q == 16'h0000)
        else $error("vector address shown without request");

endmodule
`default_nettype wire

//--- hw/irq_map_pkg.sv
/*
 * Constants and carrier types for the interrupt request mapping logic.
 * Assumes a single machine clock and a synchronous active-low reset.
 */
package irq_map_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int unsigned REQ_COUNT   = 24;
    localparam int unsigned LEVEL_W     = 2;
    localparam int unsigned REQ_IDX_W   = 5;
    localparam int unsigned VEC_W       = 16;

    // ****************************************************************
    // Vector table: request 0 at the top, each next pair two bytes lower
    // ****************************************************************
    localparam logic [15:0] VEC_BASE    = 16'hfffa;
    localparam logic [15:0] VEC_STEP    = 16'h0002;
    localparam logic [15:0] VEC_LAST    = 16'hffcc;

    // Peripheral request numbers
    localparam logic [4:0] REQ_CT0_LO   = 5'h05;
    localparam logic [4:0] REQ_CT0_HI   = 5'h06;
    localparam logic [4:0] REQ_PG1_LO   = 5'h09;
    localparam logic [4:0] REQ_PG1_HI   = 5'h0a;
    localparam logic [4:0] REQ_PG0_HI   = 5'h0c;
    localparam logic [4:0] REQ_PG0_LO   = 5'h0d;
    localparam logic [4:0] REQ_CT1_HI   = 5'h0e;
    localparam logic [4:0] REQ_CT1_LO   = 5'h16;

    // Reset value of every level field (lowest urgency, 3 = masked)
    localparam logic [1:0] LEVEL_RESET  = 2'h3;

    // Level field store reset image
    localparam logic [47:0] LEVELS_RESET = 48'hffff_ffff_ffff;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic        valid;
        logic [4:0]  req;
        logic [1:0]  level;
        logic [15:0] vec_addr;
    } irq_sel_t;

    typedef struct packed {
        logic        we;
        logic [4:0]  req;
        logic [1:0]  level;
    } level_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_POST  = 2'b01,
        ST_HOLD  = 2'b11
    } fwd_state_t;

    // Vector upper-byte address for a request number
    function automatic logic [15:0] vec_of(input logic [4:0] req);
        vec_of = VEC_BASE - {req[3:0] == 4'h0 && req[4] == 1'b0 ? 16'h0000 :
                             {10'h000, req, 1'b0}};
    endfunction

endpackage

//--- hw/irq_level_store.sv
/*
 * Level field store: 24 two-bit fields with registered read-out.
 * Assumes one writer on the machine clock.
 */
`timescale 1ns/1ps
`default_nettype none
module irq_level_store (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Write port
    input  wire irq_map_pkg::level_wr_t wr,
    // Registered read-out of all fields
    output logic [47:0]                 levels_q
);
    import irq_map_pkg::*;

    logic [47:0] levels_d;

    // Next field image
    always_comb begin
        levels_d = levels_q;
        // Numbers past the last request select no field
        if (wr.we && wr.req < 5'(REQ_COUNT)) begin
            levels_d[{wr.req, 1'b0} +: 2] = wr.level;
        end
    end

    // Field registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            levels_q <= LEVELS_RESET;
        end else begin
            levels_q <= levels_d;
        end
    end

endmodule
`default_nettype wire

//--- tb/cpu_core_model.sv
/*
 * CPU core model: holds its current level and fetches the vector pair.
 * Assumes the map's registered request outputs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Request from the map
    input  wire irq_map_pkg::irq_sel_t irq,
    input  wire logic [15:0]           vec_lo,
    // Level the program asks for
    input  wire logic [1:0]            level_set,
    // Current level and fetched vector pair
    output logic [1:0]                 cpu_level,
    output logic [31:0]                fetch_q
);
    import irq_map_pkg::*;
    logic [1:0]  level_q;
    logic [31:0] fetch_d;
    // Both vector bytes are taken while a request stands
    always_comb begin
        fetch_d = irq.valid ? {irq.vec_addr, vec_lo} : 32'h0000_0000;
    end
    // Level 3 out of reset accepts any request at levels 0 to 2
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_q <= 2'h3;
            fetch_q <= 32'h0000_0000;
        end else begin
            level_q <= level_set;
            fetch_q <= fetch_d;
        end
    end
    assign cpu_level = level_q;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
 * Self-checking bench for the interrupt vector and priority map.
 * Assumes the map answers one edge after its inputs change.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import irq_map_pkg::*;
    logic        sys_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [23:0] irq_req   = 24'h000000;
    logic [7:0]  side_irq  = 8'h00;
    level_wr_t   level_wr  = '0;
    logic [1:0]  level_set = 2'h3;
    logic [1:0]  cpu_level;
    irq_sel_t    cpu_irq_q;
    logic [15:0] vec_lo_addr_q;
    logic [47:0] levels_q;
    logic [31:0] fetch_q;
    int          bad_count   = 0;
    int          check_count = 0;
    // 50 ns clock
    always #25 sys_clk = ~sys_clk;
    interrupt_vector_priority_map i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .irq_req(irq_req),
        .timer0_lo_irq(side_irq[0]), .timer0_hi_irq(side_irq[1]),
        .timer1_hi_irq(side_irq[2]), .timer1_lo_irq(side_irq[3]),
        .programmable_pulse_generator1_lo_irq(side_irq[4]),
        .programmable_pulse_generator1_hi_irq(side_irq[5]),
        .programmable_pulse_generator0_hi_irq(side_irq[6]),
        .programmable_pulse_generator0_lo_irq(side_irq[7]),
        .level_wr(level_wr), .cpu_level(cpu_level), .cpu_irq_q(cpu_irq_q),
        .vec_lo_addr_q(vec_lo_addr_q), .levels_q(levels_q));
    cpu_core_model i_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .irq(cpu_irq_q),
        .vec_lo(vec_lo_addr_q), .level_set(level_set), .cpu_level(cpu_level),
        .fetch_q(fetch_q));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic set_level(input int r, input logic [1:0] lv);
        level_wr <= '{we: 1'b1, req: 5'(r), level: lv};
        tick(1);
    endtask
    task automatic expect_irq(input int r, input logic [1:0] lv);
        logic [15:0] v;
        v = 16'hfffa - 16'(2 * r);
        check("cpu_irq", 48'(cpu_irq_q), 48'({1'b1, 5'(r), lv, v}));
        check("vec_lo", 48'(vec_lo_addr_q), 48'(v + 16'h0001));
        check("fetch", 48'(fetch_q), 48'({v, v + 16'h0001}));
    endtask
    // Outputs while reset is held
    task automatic t_reset();
        check("cpu_irq", 48'(cpu_irq_q), 48'h0);
        check("vec_lo", 48'(vec_lo_addr_q), 48'h0);
        check("levels", levels_q, 48'hffff_ffff_ffff);
    endtask
    // Each field written by number; out of range index harmless
    task automatic t_levels();
        logic [47:0] exp;
        exp = '0;
        for (int r = 0; r < 24; r++) begin
            set_level(r, 2'(r % 3));
            exp[2 * r +: 2] = 2'(r % 3);
        end
        set_level(31, 2'h0);
        level_wr <= '0;
        tick(1);
        check("levels", levels_q, exp);
    endtask
    // Equal levels: lowest number served, dropped one by one
    task automatic t_ties();
        for (int r = 0; r < 24; r++) begin
            set_level(r, 2'h1);
        end
        level_wr <= '0;
        level_set <= 2'h2;
        irq_req <= 24'hffffff;
        tick(3);
        for (int n = 0; n < 24; n++) begin
            expect_irq(n, 2'h1);
            irq_req[n] <= 1'b0;
            tick(2);
        end
        check("valid", 48'(cpu_irq_q.valid), 48'h0);
    endtask
    // Each peripheral half on its own request number
    task automatic t_periph();
        int nums[8] = '{5, 6, 14, 22, 9, 10, 12, 13};
        for (int i = 0; i < 8; i++) begin
            side_irq <= 8'(1 << i);
            tick(2);
            expect_irq(nums[i], 2'h1);
        end
        side_irq <= 8'h00;
    endtask
    // Forwarding only when more urgent than the CPU level
    task automatic t_mask();
        set_level(0, 2'h2);
        set_level(23, 2'h0);
        level_wr <= '0;
        irq_req <= 24'h800001;
        tick(3);
        expect_irq(23, 2'h0);
        irq_req <= 24'h000001;
        tick(2);
        check("valid", 48'(cpu_irq_q.valid), 48'h0);
        level_set <= 2'h3;
        tick(3);
        expect_irq(0, 2'h2);
        irq_req <= 24'h000000;
    endtask
    // Level 0: timer 0 lower half alone, then request 0 ties with it
    task automatic t_zero();
        set_level(5, 2'h0);
        set_level(0, 2'h0);
        level_wr <= '0;
        side_irq <= 8'h01;
        tick(3);
        expect_irq(5, 2'h0);
        check("vec_lo", 48'(vec_lo_addr_q), 48'hfff1);
        irq_req <= 24'h000001;
        tick(2);
        expect_irq(0, 2'h0);
        irq_req <= 24'h000000;
        side_irq <= 8'h00;
        tick(2);
        check("valid", 48'(cpu_irq_q.valid), 48'h0);
    endtask
    // Reset in mid-run: fields back to level 3, nothing forwarded
    task automatic t_rerun();
        irq_req <= 24'h000001;
        tick(2);
        expect_irq(0, 2'h0);
        rst_n <= 1'b0;
        tick(2);
        check("cpu_irq", 48'(cpu_irq_q), 48'h0);
        check("vec_lo", 48'(vec_lo_addr_q), 48'h0);
        check("levels", levels_q, LEVELS_RESET);
        rst_n <= 1'b1;
        tick(2);
        check("valid", 48'(cpu_irq_q.valid), 48'h0);
        irq_req <= 24'h000000;
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(4);
        t_reset();
        rst_n <= 1'b1;
        t_levels();
        t_ties();
        t_periph();
        t_mask();
        t_zero();
        t_rerun();
        summarize();
    end
endmodule
`default_nettype wire
